//--- hdl/jeb_isc_top.sv
/*
  jtag tap, instruction and data paths of the eeprom configuration port.
  assumes tck from the programmer; reset_in also resets the tap.
*/
//
// Overview of operation
// [RQ1] programmer holds tms high five edges
// [RQ2] 8-bit instruction, lsb first, update-ir loads
// [RQ3] bypass scan shifts out captured status
// [RQ4] enable opcode sets configuration flip-flop
// [RQ5] verify opcode then address data scan
// [RQ6] 7-bit address msb first, bit 0 exits
// [RQ7] addressed row loaded within 20 us
// [RQ8] row bit 0 on tdo entering shift
// [RQ9] programmer compares rows, dummy address last
// [RQ10] discharge opcode drops high voltage
// [RQ11] init update-dr issues init strobe
// [RQ12] disable opcode leaves configuration at idle
// [RQ13] bypass then tap reset gives user mode
// [RQ14] program opcode loaded after enable
// [RQ15] 274 data bits then 7 address bits
// [RQ16] row written within 10 ms
// [RQ17] programmer repeats row program 96 times
// [RQ18] completion row at address 1010000
// [RQ19] flag bit 8 one, bit 9 zero
// [RQ20] standard sixteen-state tap controller
// [RQ21] erased cells read one, zero fails
`timescale 1ns/1ps
`include "jeb_defines.svh"

module jeb_isc_top
  import jeb_pkg::*;
#(
  parameter int unsigned PROGRAM_CYCLES = 32'(`JEB_PROGRAM_CYCLES),
  parameter int unsigned INIT_CYCLES = 32'(`JEB_INIT_CYCLES)
) (
  // system clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // jtag link
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  // security strap
  input wire logic secure_in,
  // device status
  output logic config_mode_out,
  output logic hv_active_out,
  output logic busy_out,
  output logic config_init_strobe_out,
  output logic completion_flag_low_out,
  output logic user_mode_out
);

  jeb_tap_state_type tap, next_tap;
  logic [`JEB_IR_WIDTH-1:0] ir_shift, ir;
  logic [`JEB_DR_BITS-1:0] dr_shift, dr_rev;
  logic bypass_bit;
  logic config_en;
  logic isc_sel;
  logic req_toggle;
  jeb_op_type req_op, next_op;
  logic [`JEB_ADDR_WIDTH-1:0] req_addr;
  logic [`JEB_ROW_BITS-1:0] req_data;
  logic ack_toggle, ack_meta, ack_sync;
  logic flag_ok, flag_meta, flag_sync;
  logic secure_meta, secure_sync;
  logic cfg_meta;
  logic [`JEB_ROW_BITS-1:0] row_data;
  logic row_ready;

  function automatic logic [`JEB_DR_BITS-1:0] reverse_dr(
    input logic [`JEB_DR_BITS-1:0] v
  );
    logic [`JEB_DR_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < `JEB_DR_BITS; i++) begin
      r[i] = v[`JEB_DR_BITS-1-i];
    end
    return r;
  endfunction : reverse_dr

  // opcodes that route the long isc register between tdi and tdo
  function automatic logic isc_op(
    input logic [`JEB_IR_WIDTH-1:0] op
  );
    return (op == `JEB_OP_VERIFY) || (op == `JEB_OP_PROGRAM);
  endfunction : isc_op

  // ==========================================
  // tap controller
  always_comb begin
    next_tap = tap;
    case (tap)
      tap_reset: next_tap = tms_in ? tap_reset : tap_idle; // [RQ1]
      tap_idle: next_tap = tms_in ? tap_sel_dr : tap_idle;
      tap_sel_dr: next_tap = tms_in ? tap_sel_ir : tap_cap_dr;
      tap_cap_dr: next_tap = tms_in ? tap_exit1_dr : tap_shift_dr;
      tap_shift_dr: next_tap = tms_in ? tap_exit1_dr : tap_shift_dr;
      tap_exit1_dr: next_tap = tms_in ? tap_upd_dr : tap_pause_dr;
      tap_pause_dr: next_tap = tms_in ? tap_exit2_dr : tap_pause_dr;
      tap_exit2_dr: next_tap = tms_in ? tap_upd_dr : tap_shift_dr;
      tap_upd_dr: next_tap = tms_in ? tap_sel_dr : tap_idle;
      tap_sel_ir: next_tap = tms_in ? tap_reset : tap_cap_ir; // [RQ13]
      tap_cap_ir: next_tap = tms_in ? tap_exit1_ir : tap_shift_ir;
      tap_shift_ir: next_tap = tms_in ? tap_exit1_ir : tap_shift_ir;
      tap_exit1_ir: next_tap = tms_in ? tap_upd_ir : tap_pause_ir;
      tap_pause_ir: next_tap = tms_in ? tap_exit2_ir : tap_pause_ir;
      tap_exit2_ir: next_tap = tms_in ? tap_upd_ir : tap_shift_ir;
      tap_upd_ir: next_tap = tms_in ? tap_sel_dr : tap_idle;
      default: next_tap = tap_reset;
    endcase
  end

  always_ff @(posedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      tap <= tap_reset;
    end else begin
      tap <= next_tap; // [RQ20]
    end
  end

  // ==========================================
  // crossings into the tck domain
  // only advances while tck runs; each scan walks enough edges first
  always_ff @(posedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= ack_toggle;
      ack_sync <= ack_meta;
    end
  end

  // slow level, only sampled at capture-ir
  always_ff @(posedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      flag_meta <= 1'b0;
      flag_sync <= 1'b0;
    end else begin
      flag_meta <= flag_ok;
      flag_sync <= flag_meta;
    end
  end

  // strap pin, asynchronous to tck
  always_ff @(posedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      secure_meta <= 1'b0;
      secure_sync <= 1'b0;
    end else begin
      secure_meta <= secure_in;
      secure_sync <= secure_meta;
    end
  end

  // row word is quasi-static once the ack has come back
  assign row_ready = (ack_sync == req_toggle);

  // ==========================================
  // instruction path
  always_ff @(posedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      ir_shift <= `JEB_OP_BYPASS;
      ir <= `JEB_OP_BYPASS;
    end else begin
      case (tap)
        tap_reset: ir <= `JEB_OP_BYPASS; // [RQ13]
        tap_cap_ir: ir_shift <= {3'h0, secure_sync, flag_sync, config_en,
          `JEB_IR_CAPTURE_LOW}; // [RQ3]
        tap_shift_ir: ir_shift <= {tdi_in, ir_shift[`JEB_IR_WIDTH-1:1]}; // [RQ2]
        tap_upd_ir: ir <= ir_shift; // [RQ2]
        default: ir <= ir;
      endcase
    end
  end

  // configuration enable: set at update-ir, cleared in idle under disable
  always_ff @(posedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      config_en <= 1'b0;
    end else if (tap == tap_reset) begin
      config_en <= 1'b0; // [RQ13]
    end else if (tap == tap_upd_ir && ir_shift == `JEB_OP_ENABLE) begin
      config_en <= 1'b1; // [RQ4]
    end else if (next_tap == tap_idle &&
      (tap == tap_upd_ir ? ir_shift : ir) == `JEB_OP_DISABLE) begin
      config_en <= 1'b0; // [RQ12]
    end
  end

  // ==========================================
  // data path
  assign isc_sel = config_en && isc_op(ir); // [RQ5] [RQ14]
  assign dr_rev = reverse_dr(dr_shift);

  always_ff @(posedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      dr_shift <= '0;
      bypass_bit <= 1'b0;
    end else begin
      case (tap)
        tap_cap_dr: begin
          bypass_bit <= 1'b0;
          if (isc_sel && ir == `JEB_OP_VERIFY) begin
            dr_shift <= {{(`JEB_DR_BITS-`JEB_ROW_BITS){1'b0}},
              row_ready ? row_data : {`JEB_ROW_BITS{1'b0}}}; // [RQ8]
          end
        end
        tap_shift_dr: begin
          bypass_bit <= tdi_in;
          dr_shift <= {tdi_in, dr_shift[`JEB_DR_BITS-1:1]}; // [RQ6] [RQ15]
        end
        default: bypass_bit <= bypass_bit;
      endcase
    end
  end

  // tdo changes on the falling edge so the programmer samples it settled
  always_ff @(negedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      tdo_oe_n_out <= 1'b1;
    end else begin
      tdo_oe_n_out <= !(tap == tap_shift_ir || tap == tap_shift_dr); // [RQ8]
    end
  end

  always_ff @(negedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      tdo_out <= 1'b1;
    end else begin
      if (tap == tap_shift_ir) begin
        tdo_out <= ir_shift[0]; // [RQ3]
      end else if (tap == tap_shift_dr) begin
        tdo_out <= isc_sel ? dr_shift[0] : bypass_bit; // [RQ8]
      end
    end
  end

  // ==========================================
  // requests to the array; address is the last 7 bits shifted, msb first
  always_comb begin
    next_op = op_idle;
    if (tap == tap_upd_ir) begin
      if (ir_shift == `JEB_OP_ENABLE) begin
        next_op = op_enable; // [RQ4]
      end else if (config_en && ir_shift == `JEB_OP_DISCHARGE) begin
        next_op = op_discharge; // [RQ10]
      end
    end else if (tap == tap_upd_dr && config_en) begin
      if (ir == `JEB_OP_VERIFY) begin
        next_op = op_load; // [RQ7]
      end else if (ir == `JEB_OP_PROGRAM) begin
        next_op = op_program; // [RQ16]
      end else if (ir == `JEB_OP_INIT) begin
        next_op = op_init; // [RQ11]
      end
    end
  end

  always_ff @(posedge tck_in or posedge reset_in) begin
    if (reset_in) begin
      req_toggle <= 1'b0;
      req_op <= op_idle;
      req_addr <= 7'h00;
      req_data <= '0;
    end else if (next_op != op_idle) begin
      req_toggle <= ~req_toggle;
      req_op <= next_op;
      req_addr <= dr_rev[`JEB_ADDR_WIDTH-1:0]; // [RQ6] [RQ18]
      req_data <= dr_rev[`JEB_DR_BITS-1:`JEB_ADDR_WIDTH]; // [RQ15] [RQ19]
    end
  end

  // ==========================================
  // array on the system clock
  jeb_nv_array #(
    .PROGRAM_CYCLES(PROGRAM_CYCLES),
    .INIT_CYCLES(INIT_CYCLES)
  ) u_array (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .req_toggle_in(req_toggle),
    .req_op_in(req_op),
    .req_addr_in(req_addr),
    .req_data_in(req_data),
    .ack_toggle_out(ack_toggle),
    .row_out(row_data),
    .busy_out(busy_out),
    .hv_active_out(hv_active_out),
    .init_strobe_out(config_init_strobe_out),
    .flag_low_out(completion_flag_low_out),
    .flag_ok_out(flag_ok),
    .user_mode_out(user_mode_out)
  );

  // configuration level into the system domain
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_meta <= 1'b0;
      config_mode_out <= 1'b0;
    end else begin
      cfg_meta <= config_en;
      config_mode_out <= cfg_meta; // [RQ12]
    end
  end

endmodule : jeb_isc_top

//--- hdl/jeb_nv_array.sv
/*
  nonvolatile row array and its timed operations on the system clock.
  assumes request fields stay stable from the request toggle until the ack.
*/
`timescale 1ns/1ps
`include "jeb_defines.svh"

module jeb_nv_array
  import jeb_pkg::*;
#(
  parameter int unsigned PROGRAM_CYCLES = 32'(`JEB_PROGRAM_CYCLES),
  parameter int unsigned INIT_CYCLES = 32'(`JEB_INIT_CYCLES)
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // request from the tck domain
  input wire logic req_toggle_in,
  input wire jeb_op_type req_op_in,
  input wire logic [`JEB_ADDR_WIDTH-1:0] req_addr_in,
  input wire logic [`JEB_ROW_BITS-1:0] req_data_in,
  // answer and status
  output logic ack_toggle_out,
  output logic [`JEB_ROW_BITS-1:0] row_out,
  output logic busy_out,
  output logic hv_active_out,
  output logic init_strobe_out,
  output logic flag_low_out,
  output logic flag_ok_out,
  output logic user_mode_out
);

  logic [`JEB_ROW_BITS-1:0] mem [`JEB_ROWS];
  logic req_meta, req_sync, req_seen;
  jeb_op_type op;
  logic [`JEB_ADDR_WIDTH-1:0] addr;
  logic [`JEB_ROW_BITS-1:0] data;
  logic [31:0] count;
  logic start, finish;

  assign start = (req_sync != req_seen) && !busy_out;
  assign finish = busy_out && (count == 32'h0);

  // ==========================================
  // request crossing and capture
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end else begin
      req_meta <= req_toggle_in;
      req_sync <= req_meta;
    end
  end

  // a request arriving while busy waits, it is not dropped
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      req_seen <= 1'b0;
      op <= op_idle;
      addr <= 7'h00;
      data <= '0;
    end else if (start) begin
      req_seen <= req_sync;
      op <= req_op_in;
      addr <= req_addr_in;
      data <= req_data_in;
    end
  end

  // ==========================================
  // operation timer
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      busy_out <= 1'b0;
      count <= 32'h0;
      ack_toggle_out <= 1'b0;
    end else if (start) begin
      busy_out <= 1'b1;
      case (req_op_in)
        op_program: count <= PROGRAM_CYCLES - 32'h1; // [RQ16]
        op_discharge: count <= 32'(`JEB_DISCHARGE_CYCLES) - 32'h1; // [RQ10]
        op_init: count <= INIT_CYCLES - 32'h1; // [RQ11]
        default: count <= 32'h0;
      endcase
    end else if (finish) begin
      busy_out <= 1'b0;
      ack_toggle_out <= req_seen;
    end else if (busy_out) begin
      count <= count - 32'h1;
    end
  end

  // ==========================================
  // array: erased cells read as one, programming only clears bits
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < `JEB_ROWS; i++) begin
        mem[i] <= '1; // [RQ21]
      end
    end else if (finish && op == op_program) begin
      mem[addr] <= mem[addr] & data; // [RQ16]
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      row_out <= '0;
    end else if (finish && op == op_load) begin
      row_out <= mem[addr]; // [RQ7]
    end
  end

  // ==========================================
  // high voltage, init and completion flags
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      hv_active_out <= 1'b0;
      init_strobe_out <= 1'b0;
      flag_low_out <= 1'b0;
      flag_ok_out <= 1'b0;
      user_mode_out <= 1'b0;
    end else begin
      if (start && req_op_in == op_program) begin
        hv_active_out <= 1'b1;
      end else if (finish && op == op_discharge) begin
        hv_active_out <= 1'b0; // [RQ10]
      end
      init_strobe_out <= start && (req_op_in == op_init); // [RQ11]
      flag_low_out <= mem[`JEB_DONE_ROW][`JEB_DONE_LOW_BIT];
      flag_ok_out <= mem[`JEB_DONE_ROW][`JEB_DONE_LOW_BIT] &
        ~mem[`JEB_DONE_ROW][`JEB_DONE_HIGH_BIT]; // [RQ19]
      if (start && req_op_in == op_enable) begin
        user_mode_out <= 1'b0;
      end else if (finish && op == op_init) begin
        user_mode_out <= flag_ok_out; // [RQ19]
      end
    end
  end

endmodule : jeb_nv_array

//--- include/jeb_defines.svh
/*
  constants of the jtag eeprom configuration port: opcodes, geometry, timing.
  assumes a 200 mhz system clock; included by the package and the modules.
*/
`ifndef JEB_DEFINES_SVH
`define JEB_DEFINES_SVH

// ==========================================
// geometry
`define JEB_IR_WIDTH 8
`define JEB_ADDR_WIDTH 7
`define JEB_ROW_BITS 274
`define JEB_DR_BITS 281
`define JEB_ROWS 128
`define JEB_DONE_ROW 7'h50
`define JEB_DONE_LOW_BIT 8
`define JEB_DONE_HIGH_BIT 9

// ==========================================
// opcodes as held in the register, bit 0 shifted first
`define JEB_OP_BYPASS 8'hff
`define JEB_OP_ENABLE 8'he8
`define JEB_OP_VERIFY 8'hee
`define JEB_OP_PROGRAM 8'hea
`define JEB_OP_DISCHARGE 8'hf0
`define JEB_OP_INIT 8'hf0
`define JEB_OP_DISABLE 8'hc0
`define JEB_IR_CAPTURE_LOW 2'h1

// ==========================================
// timing, longest device times rounded down
`define JEB_CLK_PERIOD_PS 5000
`define JEB_DISCHARGE_TIME_US 20
`define JEB_DISCHARGE_CYCLES ((`JEB_DISCHARGE_TIME_US * 1000000) / `JEB_CLK_PERIOD_PS)
`define JEB_INIT_TIME_US 800
`define JEB_INIT_CYCLES ((`JEB_INIT_TIME_US * 1000000) / `JEB_CLK_PERIOD_PS)
`define JEB_PROGRAM_TIME_MS 10
`define JEB_PROGRAM_CYCLES ((64'd`JEB_PROGRAM_TIME_MS * 64'd1000000000) / 64'd`JEB_CLK_PERIOD_PS)

`endif

//--- include/jeb_pkg.sv
/*
  types of the jtag eeprom configuration port.
  assumes jeb_defines.svh on the include path.
*/
`include "jeb_defines.svh"

package jeb_pkg;

  // ==========================================
  // tap controller states
  typedef enum logic [15:0] {
    tap_reset = 16'h0001,
    tap_idle = 16'h0002,
    tap_sel_dr = 16'h0004,
    tap_cap_dr = 16'h0008,
    tap_shift_dr = 16'h0010,
    tap_exit1_dr = 16'h0020,
    tap_pause_dr = 16'h0040,
    tap_exit2_dr = 16'h0080,
    tap_upd_dr = 16'h0100,
    tap_sel_ir = 16'h0200,
    tap_cap_ir = 16'h0400,
    tap_shift_ir = 16'h0800,
    tap_exit1_ir = 16'h1000,
    tap_pause_ir = 16'h2000,
    tap_exit2_ir = 16'h4000,
    tap_upd_ir = 16'h8000
  } jeb_tap_state_type;

  // ==========================================
  // array operations sent across to the system clock
  typedef enum logic [5:0] {
    op_idle = 6'h01,
    op_enable = 6'h02,
    op_load = 6'h04,
    op_program = 6'h08,
    op_discharge = 6'h10,
    op_init = 6'h20
  } jeb_op_type;

endpackage : jeb_pkg

//--- verif/jeb_isc_monitor.sv
/*
  checker of the configuration port status outputs and tdo.
  assumes it is bound to jeb_isc_top and sees only its ports.
*/
`timescale 1ns/1ps
`include "jeb_defines.svh"

module jeb_isc_monitor #(
  parameter int unsigned PROGRAM_CYCLES = 32'(`JEB_PROGRAM_CYCLES),
  parameter int unsigned INIT_CYCLES = 32'(`JEB_INIT_CYCLES)
) (
  // clocks and reset
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic tck_in,
  // jtag link
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_n_out,
  input wire logic secure_in,
  // status
  input wire logic config_mode_out,
  input wire logic hv_active_out,
  input wire logic busy_out,
  input wire logic config_init_strobe_out,
  input wire logic completion_flag_low_out,
  input wire logic user_mode_out
);
  // ==========================================
  // link domain
  a_tdo_holds_idle: assert property (@(negedge tck_in) disable iff (reset_in)
    tdo_oe_n_out && $past(tdo_oe_n_out) |-> $stable(tdo_out))
    else $error("tdo moved outside a shift");
  // ==========================================
  // system domain
  a_hv_needs_cfg: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(hv_active_out) |-> config_mode_out)
    else $error("high voltage without configuration mode");
  a_prog_busy_run: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(hv_active_out) |-> busy_out [*8])
    else $error("row write ended too early");
  a_strobe_one_cycle: assert property (@(posedge clock_in) disable iff (reset_in)
    config_init_strobe_out |=> !config_init_strobe_out)
    else $error("init strobe longer than one cycle");
  a_strobe_starts_busy: assert property (@(posedge clock_in) disable iff (reset_in)
    config_init_strobe_out |-> ##[0:2] busy_out && !hv_active_out)
    else $error("init not running or voltage still high");
  a_user_needs_flag: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(user_mode_out) |-> completion_flag_low_out && !busy_out)
    else $error("user mode without completion flag");
  a_hv_drop_free: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(hv_active_out) |-> ##[0:1] !busy_out)
    else $error("busy after discharge end");
  a_enable_user_off: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(config_mode_out) |-> ##[0:8] !user_mode_out)
    else $error("user mode kept after enable");
  a_user_idle_hv: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(user_mode_out) |-> !hv_active_out)
    else $error("user mode with high voltage");
endmodule : jeb_isc_monitor

bind jeb_isc_top jeb_isc_monitor #(
  .PROGRAM_CYCLES(PROGRAM_CYCLES),
  .INIT_CYCLES(INIT_CYCLES)
) u_jeb_isc_monitor (
  .clock_in(clock_in), .reset_in(reset_in), .tck_in(tck_in), .tms_in(tms_in),
  .tdi_in(tdi_in), .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .secure_in(secure_in),
  .config_mode_out(config_mode_out), .hv_active_out(hv_active_out), .busy_out(busy_out),
  .config_init_strobe_out(config_init_strobe_out),
  .completion_flag_low_out(completion_flag_low_out), .user_mode_out(user_mode_out)
);

//--- verif/jeb_isc_top_test.sv
/*
  testbench of jeb_isc_top: blank check, program, readback, close.
  assumes shortened program and init counts; 5 ns system clock.
*/
`timescale 1ns/1ps

module jeb_isc_top_test;
  localparam int unsigned PROG_N = 50;
  localparam int unsigned INIT_N = 40;
  localparam logic [273:0] ONES = '1;
  logic clock_in, reset_in, secure_in, tck, tms, tdi, tdo_out, tdo_oe_n_out;
  logic config_mode_out, hv_active_out, busy_out, config_init_strobe_out;
  logic completion_flag_low_out, user_mode_out;
  logic [7:0] cap8;
  logic [273:0] row;
  logic [273:0] pattern;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  jeb_isc_top #(.PROGRAM_CYCLES(PROG_N), .INIT_CYCLES(INIT_N)) u_jeb_isc_top (
    .clock_in(clock_in), .reset_in(reset_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .secure_in(secure_in),
    .config_mode_out(config_mode_out), .hv_active_out(hv_active_out), .busy_out(busy_out),
    .config_init_strobe_out(config_init_strobe_out),
    .completion_flag_low_out(completion_flag_low_out), .user_mode_out(user_mode_out));
  // released tdo floats to its pull-up level
  jeb_prog_model u_jeb_prog_model (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .tdo_in(tdo_oe_n_out ? 1'b1 : tdo_out));

  // ==========================================
  // clock, timeout, compares
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // whole run is near 64000 cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic cmp_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_bit
  task automatic cmp_vec(input logic [273:0] g, input logic [273:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_vec
  task automatic wait_free();
    int n;
    n = 0;
    repeat (12) @(negedge clock_in);
    while (busy_out !== 1'b0 && n < 5000) begin
      @(negedge clock_in);
      n++;
    end
    cmp_bit(busy_out, 1'b0);
  endtask : wait_free
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // ==========================================
  // scenarios
  task automatic t_status_enable();
    u_jeb_prog_model.reset_tap();
    u_jeb_prog_model.ir(8'hff, cap8);
    cmp_vec(274'(cap8), 274'h11);
    u_jeb_prog_model.ir(8'he8, cap8);
    wait_free();
    cmp_bit(config_mode_out, 1'b1);
  endtask : t_status_enable
  task automatic t_blank();
    u_jeb_prog_model.ir(8'hee, cap8);
    u_jeb_prog_model.scan(ONES, 7'h00, 7, row);
    repeat (4000) @(negedge clock_in);
    u_jeb_prog_model.scan(ONES, 7'h01, 281, row);
    cmp_vec(row, ONES);
    repeat (4000) @(negedge clock_in);
    u_jeb_prog_model.scan(ONES, 7'h7f, 281, row);
    cmp_vec(row, ONES);
  endtask : t_blank
  task automatic t_program();
    pattern = ~(274'h1 | (274'h1 << 273) | 274'h2a0);
    u_jeb_prog_model.ir(8'hea, cap8);
    u_jeb_prog_model.scan(pattern, 7'h05, 281, row);
    repeat (8) @(negedge clock_in);
    cmp_bit(busy_out, 1'b1);
    cmp_bit(hv_active_out, 1'b1);
    wait_free();
    for (int r = 0; r < 96; r++) begin
      if (r != 5) begin
        u_jeb_prog_model.scan(~(274'h1 << r), 7'(r), 281, row);
        wait_free();
      end
    end
    u_jeb_prog_model.scan(~(274'h1 << 9), 7'h50, 281, row);
    wait_free();
    cmp_bit(completion_flag_low_out, 1'b1);
    secure_in = 1'b0;
    u_jeb_prog_model.ir(8'hee, cap8);
    cmp_vec(274'(cap8), 274'h0d);
    u_jeb_prog_model.scan(ONES, 7'h05, 7, row);
    repeat (4000) @(negedge clock_in);
    u_jeb_prog_model.scan(ONES, 7'h5f, 281, row);
    cmp_vec(row, pattern);
    repeat (4000) @(negedge clock_in);
    u_jeb_prog_model.scan(ONES, 7'h7f, 281, row);
    cmp_vec(row, ~(274'h1 << 95));
  endtask : t_program
  task automatic t_close();
    u_jeb_prog_model.ir(8'hf0, cap8);
    wait_free();
    cmp_bit(hv_active_out, 1'b0);
    u_jeb_prog_model.ir(8'hf0, cap8);
    wait_free();
    u_jeb_prog_model.init_pulse();
    wait_free();
    cmp_bit(user_mode_out, 1'b1);
    u_jeb_prog_model.ir(8'hc0, cap8);
    repeat (6) @(negedge clock_in);
    cmp_bit(config_mode_out, 1'b0);
    u_jeb_prog_model.ir(8'hff, cap8);
    u_jeb_prog_model.to_reset();
    repeat (6) @(negedge clock_in);
    cmp_bit(user_mode_out, 1'b1);
  endtask : t_close

  initial begin
    reset_in = 1'b1;
    secure_in = 1'b1;
    repeat (2) @(negedge clock_in);
    reset_in = 1'b0;
    t_status_enable();
    t_blank();
    t_program();
    t_close();
    print_verdict();
  end
endmodule : jeb_isc_top_test

//--- verif/jeb_prog_model.sv
/*
  jtag programmer model: drives tck, tms, tdi and samples tdo.
  assumes tdo changes on falling tck; tck stands still between frames.
*/
`timescale 1ns/1ps

module jeb_prog_model (
  // jtag link
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // ==========================================
  // one 6 ns tck period, tdo taken before the rising edge
  task automatic step(input logic t, input logic d, output logic o);
    tms_out = t;
    tdi_out = d;
    #1 o = tdo_in;
    #2 tck_out = 1'b1;
    #3 tck_out = 1'b0;
  endtask : step
  task automatic walk(input logic [4:0] path, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(path[i], tdi_out, o);
    end
  endtask : walk
  // ==========================================
  // frames
  task automatic reset_tap();
    walk(5'h1f, 5);
    walk(5'h00, 1);
  endtask : reset_tap
  task automatic ir(input logic [7:0] op, output logic [7:0] cap);
    walk(5'h03, 4);
    for (int i = 0; i < 8; i++) begin
      step(i == 7, op[i], cap[i]);
    end
    walk(5'h01, 2);
  endtask : ir
  task automatic dr(input logic [280:0] v, input int n, output logic [280:0] cap);
    cap = '1;
    walk(5'h01, 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], cap[i]);
    end
    walk(5'h01, 2);
  endtask : dr
  task automatic scan(input logic [273:0] d, input logic [6:0] a, input int n,
                      output logic [273:0] row);
    logic [280:0] v;
    logic [280:0] c;
    for (int i = 0; i < 274; i++) v[i] = d[273 - i];
    for (int i = 0; i < 7; i++) v[n - 7 + i] = a[6 - i];
    dr(v, n, c);
    row = c[273:0];
  endtask : scan
  // sel-dr, cap-dr, exit1-dr, update-dr, idle: no shift at all
  task automatic init_pulse();
    walk(5'h0d, 5);
  endtask : init_pulse
  task automatic to_reset();
    walk(5'h07, 3);
  endtask : to_reset
endmodule : jeb_prog_model
